// [rtl/cssq_consts.svh]
// constants for the touch sense conversion sequencer
// assumes inclusion by bare name from rtl files
`ifndef CSSQ_CONSTS_SVH
`define CSSQ_CONSTS_SVH
`define CSSQ_OFF_CONFIG   8'h00
`define CSSQ_OFF_CONTROL  8'h04
`define CSSQ_OFF_SCAN_ST  8'h08
`define CSSQ_OFF_SCAN_END 8'h0c
`define CSSQ_OFF_CHAN     8'h10
`define CSSQ_OFF_ANALOG   8'h14
`define CSSQ_OFF_STATUS   8'h18
`define CSSQ_OFF_IRQ_EN   8'h1c
`define CSSQ_OFF_PRIO     8'h20
`define CSSQ_SRC_MSB      6
`define CSSQ_SRC_LSB      4
`define CSSQ_ACC_MSB      1
`define CSSQ_ACC_LSB      0
`define CSSQ_BUSY_BIT     0
`define CSSQ_ST_DONE      0
`define CSSQ_ST_GT        1
`define CSSQ_CFG_RST      8'h00
`define CSSQ_CHAN_RST     5'h1f
`define CSSQ_ACC_RUN_W    7
`define CSSQ_ACC_1        7'h01
`define CSSQ_ACC_4        7'h04
`define CSSQ_ACC_16       7'h10
`define CSSQ_ACC_64       7'h40
`endif

// [rtl/cssq_pkg.sv]
// types for the touch sense conversion sequencer
// assumes no other package
package cssq_pkg;
	typedef enum logic [2:0] {
		CSSQ_SRC_BUSY  = 3'b000,
		CSSQ_SRC_T0    = 3'b001,
		CSSQ_SRC_T2    = 3'b010,
		CSSQ_SRC_T1    = 3'b011,
		CSSQ_SRC_RSV4  = 3'b100,
		CSSQ_SRC_RSV5  = 3'b101,
		CSSQ_SRC_CONT  = 3'b110,
		CSSQ_SRC_SCAN  = 3'b111
	} cssq_src_t;
	typedef enum logic [0:0] {
		CSSQ_IDLE = 1'b0,
		CSSQ_CONV = 1'b1
	} cssq_state_t;
endpackage : cssq_pkg

// [rtl/cssq_next_chan.sv]
// next channel picker for auto-scan
// assumes channel numbers index the analog pin mask directly
`timescale 1ns/100ps
module cssq_next_chan #(
	parameter int CH_W  = 5,
	parameter int NPINS = 16
) (
	input  wire logic [CH_W-1:0]  cur_i,
	input  wire logic [CH_W-1:0]  first_i,
	input  wire logic [CH_W-1:0]  last_i,
	input  wire logic [NPINS-1:0] analog_i,
	output logic      [CH_W-1:0]  next_o
);
	logic [NPINS-1:0] hit;
	logic [CH_W-1:0]  pick;
	logic             found;

	// candidate pins strictly above current, not past the end
	for (genvar g = 0; g < NPINS; g++) begin : g_hit
		assign hit[g] = analog_i[g] && (CH_W'(g) > cur_i) &&
			(CH_W'(g) <= last_i);
	end

	always_comb begin
		pick  = last_i;
		found = 1'b0;
		for (int i = 0; i < NPINS; i++) begin
			if (hit[i] && !found) begin
				pick  = CH_W'(i);
				found = 1'b1;
			end
		end
	end

	// wrap back after the end channel, else lowest analog pin above, or the end channel if none
	assign next_o = (cur_i == last_i) ? first_i : pick;
endmodule : cssq_next_chan

// [rtl/cssq_seq.sv]
// touch sense conversion sequencer with apb register slave
// assumes an analog converter that answers each start with a done pulse
//
// What this block does
// - the start source field picks busy write, timer 0, 2, 1, continuous or scan.
// - in busy-write mode a one written to the busy bit starts a conversion.
// - in both continuous modes nothing converts until the busy bit is set.
// - the done interrupt reaches the output only when its enable bit 0 is set.
// - with accumulation the done interrupt comes after the group's last one.
// - start source value 111b enables auto-scan.
// - in scan mode a write to scan start is copied into the channel select.
// - in scan mode a one written to the busy bit starts the scan.
// - after each group the scan moves to the next higher analog pin.
// - after converting at the end channel the scan reloads the start channel.
// - a scan skips channels that are not analog, except the start and end channels.
// - scanning goes on in suspend and a greater-than event wakes the device.
// - the done interrupt is high priority when its priority bit is one.
`timescale 1ns/100ps
`include "cssq_consts.svh"
module cssq_seq #(
	parameter int CH_W  = 5,
	parameter int NPINS = 16
) (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        t0_ovf_i,
	input  wire logic        t1_ovf_i,
	input  wire logic        t2_ovf_i,
	input  wire logic        conv_done_i,
	input  wire logic        conv_gt_i,
	input  wire logic        suspend_i,
	output logic             conv_start_o,
	output logic [CH_W-1:0]  channel_o,
	output logic             irq_o,
	output logic             irq_high_o,
	output logic             wake_o
);
	logic                      rst_s1;
	logic                      rst_n;
	logic [7:0]                sense_config_reg;
	logic                      conversion_busy_bit;
	logic [CH_W-1:0]           scan_start_channel;
	logic [CH_W-1:0]           scan_end_channel;
	logic [CH_W-1:0]           sense_channel_select;
	logic [NPINS-1:0]          analog_pins;
	logic [1:0]                irq_status;
	logic [1:0]                ext_irq_enable_two;
	logic [1:0]                ext_irq_priority_two;
	logic [`CSSQ_ACC_RUN_W-1:0] acc_cnt;
	logic [`CSSQ_ACC_RUN_W-1:0] acc_target;
	logic [CH_W-1:0]           next_chan;
	cssq_pkg::cssq_state_t     state;
	cssq_pkg::cssq_src_t       src;
	logic                      acc_wr;
	logic [31:0]               rd_mux;
	logic                      wr_ctl;
	logic                      wr_ss;
	logic                      wr_chan;
	logic                      busy_set;
	logic                      tmr_hit;
	logic                      go;
	logic                      grp_done;
	logic                      cont_mode;
	logic                      keep_going;
	logic                      hit_map;

	// reset release through two flops
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// apb decode, zero wait states
	assign acc_wr   = psel_i && penable_i && pwrite_i;
	assign wr_ctl   = acc_wr && paddr_i == `CSSQ_OFF_CONTROL;
	assign wr_ss    = acc_wr && paddr_i == `CSSQ_OFF_SCAN_ST;
	assign wr_chan  = acc_wr && paddr_i == `CSSQ_OFF_CHAN;
	assign pready_o = 1'b1;

	always_comb begin
		unique case (paddr_i)
			`CSSQ_OFF_CONFIG, `CSSQ_OFF_CONTROL, `CSSQ_OFF_SCAN_ST,
			`CSSQ_OFF_SCAN_END, `CSSQ_OFF_CHAN, `CSSQ_OFF_ANALOG,
			`CSSQ_OFF_STATUS, `CSSQ_OFF_IRQ_EN,
			`CSSQ_OFF_PRIO: hit_map = 1'b1;
			default:        hit_map = 1'b0;
		endcase
	end
	assign pslverr_o = psel_i && penable_i && !hit_map;

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (paddr_i)
			`CSSQ_OFF_CONFIG:   rd_mux[7:0] = sense_config_reg;
			`CSSQ_OFF_CONTROL:
				rd_mux[`CSSQ_BUSY_BIT] = conversion_busy_bit;
			`CSSQ_OFF_SCAN_ST:  rd_mux[CH_W-1:0] = scan_start_channel;
			`CSSQ_OFF_SCAN_END: rd_mux[CH_W-1:0] = scan_end_channel;
			`CSSQ_OFF_CHAN:     rd_mux[CH_W-1:0] = sense_channel_select;
			`CSSQ_OFF_ANALOG:   rd_mux[NPINS-1:0] = analog_pins;
			`CSSQ_OFF_STATUS:   rd_mux[1:0] = irq_status;
			`CSSQ_OFF_IRQ_EN:   rd_mux[1:0] = ext_irq_enable_two;
			`CSSQ_OFF_PRIO:     rd_mux[1:0] = ext_irq_priority_two;
			default:            rd_mux = 32'h0000_0000;
		endcase
	end

	// read data caught in setup, stands through the access cycle
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			prdata_o <= 32'h0000_0000;
		end else if (psel_i && !penable_i) begin
			prdata_o <= rd_mux;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sense_config_reg     <= `CSSQ_CFG_RST;
			scan_start_channel   <= '0;
			scan_end_channel     <= '0;
			analog_pins          <= '0;
			ext_irq_enable_two   <= 2'h0;
			ext_irq_priority_two <= 2'h0;
		end else if (acc_wr) begin
			unique case (paddr_i)
				`CSSQ_OFF_CONFIG:   sense_config_reg <= pwdata_i[7:0];
				`CSSQ_OFF_SCAN_ST:
					scan_start_channel <= pwdata_i[CH_W-1:0];
				`CSSQ_OFF_SCAN_END:
					scan_end_channel <= pwdata_i[CH_W-1:0];
				`CSSQ_OFF_ANALOG:   analog_pins <= pwdata_i[NPINS-1:0];
				`CSSQ_OFF_IRQ_EN:   ext_irq_enable_two <= pwdata_i[1:0];
				`CSSQ_OFF_PRIO:     ext_irq_priority_two <= pwdata_i[1:0];
				default:            ;
			endcase
		end
	end

	// start source and group size
	assign src = cssq_pkg::cssq_src_t'(
		sense_config_reg[`CSSQ_SRC_MSB:`CSSQ_SRC_LSB]);
	assign cont_mode = src == cssq_pkg::CSSQ_SRC_CONT ||
		src == cssq_pkg::CSSQ_SRC_SCAN;

	always_comb begin
		unique case (sense_config_reg[`CSSQ_ACC_MSB:`CSSQ_ACC_LSB])
			2'h0: acc_target = `CSSQ_ACC_1;
			2'h1: acc_target = `CSSQ_ACC_4;
			2'h2: acc_target = `CSSQ_ACC_16;
			2'h3: acc_target = `CSSQ_ACC_64;
		endcase
	end

	always_comb begin
		unique case (src)
			cssq_pkg::CSSQ_SRC_T0: tmr_hit = t0_ovf_i;
			cssq_pkg::CSSQ_SRC_T2: tmr_hit = t2_ovf_i;
			cssq_pkg::CSSQ_SRC_T1: tmr_hit = t1_ovf_i;
			default:               tmr_hit = 1'b0;
		endcase
	end

	assign busy_set = wr_ctl && pwdata_i[`CSSQ_BUSY_BIT];
	// busy write starts every mode, including the timer modes; timer overflow also starts the timer modes
	assign go = (state == cssq_pkg::CSSQ_IDLE) &&
		((!tmr_hit && (busy_set || (cont_mode && conversion_busy_bit))) ||
		tmr_hit);
	assign grp_done = state == cssq_pkg::CSSQ_CONV && conv_done_i &&
		acc_cnt == acc_target - `CSSQ_ACC_RUN_W'(1);
	assign keep_going = cont_mode && conversion_busy_bit;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			conversion_busy_bit <= 1'b0;
		end else if (busy_set || (go && tmr_hit)) begin
			conversion_busy_bit <= 1'b1;
		end else if (wr_ctl) begin
			conversion_busy_bit <= 1'b0;
		end else if (grp_done && !cont_mode) begin
			conversion_busy_bit <= 1'b0;
		end
	end

	// conversion sequencer, no gating by suspend
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state        <= cssq_pkg::CSSQ_IDLE;
			acc_cnt      <= '0;
			conv_start_o <= 1'b0;
		end else begin
			conv_start_o <= 1'b0;
			unique case (state)
				cssq_pkg::CSSQ_IDLE: begin
					if (go) begin
						state        <= cssq_pkg::CSSQ_CONV;
						acc_cnt      <= '0;
						conv_start_o <= 1'b1;
					end
				end
				cssq_pkg::CSSQ_CONV: begin
					if (grp_done) begin
						acc_cnt <= '0;
						if (keep_going) begin
							conv_start_o <= 1'b1;
						end else begin
							state <= cssq_pkg::CSSQ_IDLE;
						end
					end else if (conv_done_i) begin
						acc_cnt      <= acc_cnt + `CSSQ_ACC_RUN_W'(1);
						conv_start_o <= 1'b1;
					end
				end
			endcase
		end
	end

	cssq_next_chan #(
		.CH_W  (CH_W),
		.NPINS (NPINS)
	) u_next (
		.cur_i    (sense_channel_select),
		.first_i  (scan_start_channel),
		.last_i   (scan_end_channel),
		.analog_i (analog_pins),
		.next_o   (next_chan)
	);

	// channel select: software write, scan-start copy, scan step
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sense_channel_select <= `CSSQ_CHAN_RST;
		end else if (wr_chan) begin
			sense_channel_select <= pwdata_i[CH_W-1:0];
		end else if (wr_ss && src == cssq_pkg::CSSQ_SRC_SCAN) begin
			sense_channel_select <= pwdata_i[CH_W-1:0];
		end else if (grp_done && src == cssq_pkg::CSSQ_SRC_SCAN) begin
			sense_channel_select <= next_chan;
		end
	end
	assign channel_o = sense_channel_select;

	// sticky flags, write one to clear, set wins
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= 2'h0;
		end else begin
			irq_status[`CSSQ_ST_DONE] <= grp_done ||
				(irq_status[`CSSQ_ST_DONE] && !(acc_wr &&
				paddr_i == `CSSQ_OFF_STATUS &&
				pwdata_i[`CSSQ_ST_DONE]));
			irq_status[`CSSQ_ST_GT] <= conv_gt_i ||
				(irq_status[`CSSQ_ST_GT] && !(acc_wr &&
				paddr_i == `CSSQ_OFF_STATUS && pwdata_i[`CSSQ_ST_GT]));
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_o      <= 1'b0;
			irq_high_o <= 1'b0;
			wake_o     <= 1'b0;
		end else begin
			irq_o      <= |(irq_status & ext_irq_enable_two);
			irq_high_o <= |(irq_status & ext_irq_enable_two &
				ext_irq_priority_two);
			wake_o     <= suspend_i && src == cssq_pkg::CSSQ_SRC_SCAN &&
				conv_gt_i;
		end
	end

	AST_SW_START: assert property (@(posedge clk_i) disable iff (!rst_n)
		state == cssq_pkg::CSSQ_IDLE && src == cssq_pkg::CSSQ_SRC_BUSY &&
		busy_set |=> conv_start_o && state == cssq_pkg::CSSQ_CONV)
		else $error("busy write did not start a conversion");
	AST_CONT_WAIT: assert property (@(posedge clk_i) disable iff (!rst_n)
		state == cssq_pkg::CSSQ_IDLE && cont_mode && !conversion_busy_bit &&
		!busy_set |=> !conv_start_o)
		else $error("continuous mode started without busy");
	AST_IRQ_GATE: assert property (@(posedge clk_i) disable iff (!rst_n)
		irq_o |-> $past(|(irq_status & ext_irq_enable_two)))
		else $error("interrupt without enabled flag");
	AST_GROUP_LAST: assert property (@(posedge clk_i) disable iff (!rst_n)
		grp_done |-> conv_done_i && acc_cnt == acc_target - `CSSQ_ACC_1)
		else $error("done flagged before last conversion");
	AST_SS_COPY: assert property (@(posedge clk_i) disable iff (!rst_n)
		wr_ss && !wr_chan && src == cssq_pkg::CSSQ_SRC_SCAN |=>
		channel_o == $past(pwdata_i[CH_W-1:0]))
		else $error("scan start not copied to channel");
	AST_WRAP: assert property (@(posedge clk_i) disable iff (!rst_n)
		grp_done && src == cssq_pkg::CSSQ_SRC_SCAN && !wr_chan && !wr_ss &&
		channel_o == scan_end_channel |=> channel_o == $past(scan_start_channel))
		else $error("scan did not wrap to start");
	AST_BUSY_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n)
		grp_done && !cont_mode && !wr_ctl |=>
		!conversion_busy_bit && irq_status[`CSSQ_ST_DONE])
		else $error("group end did not clear busy");
	AST_TMR_IGNORE: assert property (@(posedge clk_i) disable iff (!rst_n)
		state == cssq_pkg::CSSQ_CONV && !conv_done_i && tmr_hit |=>
		!conv_start_o)
		else $error("overflow restarted a running conversion");
	AST_PRIO: assert property (@(posedge clk_i) disable iff (!rst_n)
		irq_high_o |-> irq_o && $past(|ext_irq_priority_two))
		else $error("high priority without priority bit");
	AST_WAKE: assert property (@(posedge clk_i) disable iff (!rst_n)
		suspend_i && src == cssq_pkg::CSSQ_SRC_SCAN && conv_gt_i |=> wake_o)
		else $error("greater-than event did not wake");
endmodule : cssq_seq

// [test/cssq_electrode_model.sv]
// converter and electrode model: each start is answered by one done pulse
// assumes the sequencer issues starts one at a time
`timescale 1ns/100ps
module cssq_electrode_model (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        start_i,
	input  wire logic        slow_i,
	input  wire logic        gt_req_i,
	output logic             done_o,
	output logic             gt_o,
	output logic      [15:0] starts_o
);
	logic [3:0] wait_cnt;
	logic       run;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run <= 1'b0;
			wait_cnt <= 4'h0;
			done_o <= 1'b0;
			gt_o <= 1'b0;
			starts_o <= 16'h0;
		end else begin
			done_o <= 1'b0;
			gt_o <= 1'b0;
			if (start_i) begin
				starts_o <= starts_o + 16'h1;
				run <= 1'b1;
				wait_cnt <= slow_i ? 4'hc : 4'h2;
			end else if (run) begin
				if (wait_cnt == 4'h0) begin
					run <= 1'b0;
					done_o <= 1'b1;
					gt_o <= gt_req_i;
				end else begin
					wait_cnt <= wait_cnt - 4'h1;
				end
			end
		end
	end
endmodule : cssq_electrode_model

// [test/cssq_seq_tb.sv]
// self-checking bench for the conversion sequencer
// assumes the electrode model answers each conversion start
`timescale 1ns/100ps
`include "cssq_consts.svh"
module cssq_seq_tb;
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [2:0]  tmr;
	logic        done, gt, suspend, start, irq, irq_hi, wake, slow, gt_req, e;
	logic [4:0]  chan;
	logic [15:0] starts, base;
	logic [4:0]  ch_log[$];
	int          error_cnt = 0;
	int          checked = 0;
	cssq_pkg::cssq_src_t src[3] = '{cssq_pkg::CSSQ_SRC_T0,
		cssq_pkg::CSSQ_SRC_T2, cssq_pkg::CSSQ_SRC_T1};
	logic [2:0]  msk[3] = '{3'h1, 3'h4, 3'h2};
	logic [4:0]  exp_ch[6] = '{5'h02, 5'h04, 5'h06, 5'h02, 5'h04, 5'h06};
	logic [15:0] acc_n[3] = '{16'h4, 16'h10, 16'h40};
	cssq_seq u_dut (.clk_i(clk), .rstn_i(rstn), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .t0_ovf_i(tmr[0]), .t1_ovf_i(tmr[1]),
		.t2_ovf_i(tmr[2]), .conv_done_i(done), .conv_gt_i(gt),
		.suspend_i(suspend), .conv_start_o(start), .channel_o(chan),
		.irq_o(irq), .irq_high_o(irq_hi), .wake_o(wake));
	cssq_electrode_model u_model (.clk_i(clk), .rstn_i(rstn),
		.start_i(start), .slow_i(slow), .gt_req_i(gt_req), .done_o(done),
		.gt_o(gt), .starts_o(starts));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// channel seen at each start
	always @(posedge clk) if (start === 1'b1) ch_log.push_back(chan);
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task automatic fail_now();
		error_cnt++;
		conclude();
	endtask : fail_now
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (n > 16) fail_now();
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask : rd_chk
	task automatic poll_done();
		for (int i = 0; i < 400; i++) begin
			apb(1'b0, `CSSQ_OFF_STATUS, 32'h0);
			if (q[`CSSQ_ST_DONE] === 1'b1) return;
		end
		fail_now();
	endtask : poll_done
	task automatic wait_starts(input logic [15:0] n);
		for (int i = 0; i < 1200; i++) begin
			@(posedge clk);
			if (starts >= n) return;
		end
		fail_now();
	endtask : wait_starts
	task automatic pulse(input logic [2:0] m);
		@(posedge clk);
		tmr <= m;
		@(posedge clk);
		tmr <= 3'h0;
	endtask : pulse
	initial begin
		rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; tmr = 3'h0; suspend = 1'b0;
		slow = 1'b1; gt_req = 1'b0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		chk({27'h0, chan}, {27'h0, `CSSQ_CHAN_RST});
		rd_chk(`CSSQ_OFF_CONFIG, 32'h0);
		apb(1'b0, 8'h24, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			wr(`CSSQ_OFF_IRQ_EN, {31'h0, i != 2});
			wr(`CSSQ_OFF_PRIO, {31'h0, i != 1});
			base = starts;
			wr(`CSSQ_OFF_CONTROL, 32'h1);
			poll_done();
			chk(32'(starts - base), 32'h1);
			rd_chk(`CSSQ_OFF_CONTROL, 32'h0);
			repeat (2) @(posedge clk);
			chk({31'h0, irq}, {31'h0, i != 2});
			chk({31'h0, irq_hi}, {31'h0, i == 0});
			wr(`CSSQ_OFF_STATUS, 32'h1);
		end
		$display("test busy write done");
		wr(`CSSQ_OFF_IRQ_EN, 32'h1);
		for (int j = 0; j < 3; j++) begin
			wr(`CSSQ_OFF_CONFIG, 32'(j + 1));
			base = starts;
			wr(`CSSQ_OFF_CONTROL, 32'h1);
			wait_starts(base + acc_n[j]);
			chk({31'h0, irq}, 32'h0);
			poll_done();
			chk(32'(starts - base), {16'h0, acc_n[j]});
			repeat (2) @(posedge clk);
			chk({31'h0, irq}, 32'h1);
			wr(`CSSQ_OFF_STATUS, 32'h1);
		end
		$display("test accumulate done");
		for (int i = 0; i < 3; i++) begin
			wr(`CSSQ_OFF_CONFIG, {25'h0, src[i], 4'h0});
			base = starts;
			pulse(3'h7 & ~msk[i]);
			repeat (20) @(posedge clk);
			chk(32'(starts - base), 32'h0);
			pulse(msk[i]);
			repeat (3) @(posedge clk);
			pulse(msk[i]);
			poll_done();
			chk(32'(starts - base), 32'h1);
			wr(`CSSQ_OFF_STATUS, 32'h1);
		end
		$display("test timers done");
		wr(`CSSQ_OFF_CONFIG, 32'h60);
		base = starts;
		repeat (20) @(posedge clk);
		chk(32'(starts - base), 32'h0);
		wr(`CSSQ_OFF_CONTROL, 32'h1);
		wait_starts(base + 16'h3);
		wr(`CSSQ_OFF_CONTROL, 32'h0);
		repeat (40) @(posedge clk);
		base = starts;
		repeat (30) @(posedge clk);
		chk(32'(starts - base), 32'h0);
		$display("test continuous done");
		slow <= 1'b0;
		wr(`CSSQ_OFF_ANALOG, 32'h14);
		wr(`CSSQ_OFF_CONFIG, 32'h70);
		wr(`CSSQ_OFF_SCAN_END, 32'h6);
		wr(`CSSQ_OFF_SCAN_ST, 32'h2);
		@(posedge clk);
		chk({27'h0, chan}, 32'h2);
		ch_log.delete();
		base = starts;
		wr(`CSSQ_OFF_CONTROL, 32'h1);
		wait_starts(base + 16'h6);
		for (int i = 0; i < 6; i++)
			chk({27'h0, ch_log[i]}, {27'h0, exp_ch[i]});
		suspend <= 1'b1;
		gt_req <= 1'b1;
		for (int i = 0; i <= 60; i++) begin
			@(posedge clk);
			if (wake === 1'b1) break;
			if (i == 60) fail_now();
		end
		chk({31'h0, wake}, 32'h1);
		wr(`CSSQ_OFF_CONTROL, 32'h0);
		$display("test scan done");
		conclude();
	end
endmodule : cssq_seq_tb
